//--- nvsram_access_cycle.sv
// One read or write strobe cycle on the SRAM pins.
// Assumes dataInSync is already synchronised; start is ignored while busy.
`timescale 1ns/10ps
`default_nettype none
module nvsram_access_cycle (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic isWrite,
   input wire logic [nvsram_host_pkg::ADDR_W-1:0] addr,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] wdata,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] dataInSync,
   output nvsram_host_pkg::pins_t pins,
   output logic [nvsram_host_pkg::DATA_W-1:0] dataOut,
   output logic dataOe,
   output logic [nvsram_host_pkg::DATA_W-1:0] rdata,
   output logic busy,
   output logic done
);
   localparam logic [3:0] LAST = 4'(nvsram_host_pkg::ACCESS_CYCLES
                                    + nvsram_host_pkg::SYNC_STAGES);
   logic [3:0] cnt;
   wire endNow = busy && (cnt == LAST);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         cnt <= 4'h0;
         rdata <= '0;
         dataOut <= '0;
         dataOe <= 1'b0;
         pins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0};
      end else begin
         done <= endNow;
         if (start && !busy) begin
            busy <= 1'b1;
            cnt <= 4'h0;
            pins.addr <= addr;
            pins.ceN <= 1'b0;
            // Write keeps output enable high to avoid bus contention
            pins.oeN <= isWrite;
            pins.weN <= !isWrite;
            dataOut <= wdata;
            dataOe <= isWrite;
         end else if (endNow) begin
            busy <= 1'b0;
            rdata <= dataInSync;
            pins.ceN <= 1'b1;
            pins.oeN <= 1'b1;
            pins.weN <= 1'b1;
            dataOe <= 1'b0;
         end else if (busy) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- nvsram_device_model.sv
// Behavioural nonvolatile SRAM device as seen from its pins.
// Assumes strobes of at least 100 ns and one access at a time.
`timescale 1ns/10ps
`default_nettype none
module nvsram_device_model #(
   parameter int BUSY_NS = 300,
   parameter int HOLD_NS = 400
) (
   input wire nvsram_host_pkg::pins_t pins,
   input wire logic [7:0] hostData,
   input wire logic busyPullLow,
   output logic [7:0] devData,
   output logic busyPin,
   output int stores,
   output int recalls,
   output logic autoStore,
   output logic autoStoreNv
);
   logic [7:0] mem [0:32767];
   logic [7:0] nvMem [0:32767];
   logic [13:0] seqAddr [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
   logic [13:0] a;
   logic rd;
   logic flt = 1'b0;
   logic busy = 1'b0;
   logic wrote = 1'b0;
   int step = 0;
   realtime freeAt = 0.0;
   // writes locked out for a while after busy ends
   always @(posedge busyPin) begin
      freeAt = $realtime + HOLD_NS;
   end
   initial begin
      mem = '{default: 8'h00};
      nvMem = mem;
      stores = 0;
      recalls = 0;
      autoStore = 1'b1;
      autoStoreNv = 1'b1;
   end
   assign busyPin = !(busy || busyPullLow);
   // pattern stands in for a floating bus
   assign devData = (!pins.ceN && !pins.oeN && !flt) ? mem[pins.addr] : ~mem[pins.addr];
   task automatic nv_store();
      busy = 1'b1;
      #BUSY_NS;
      nvMem = mem;
      autoStoreNv = autoStore;
      stores++;
      wrote = 1'b0;
      busy = 1'b0;
   endtask
   always @(posedge busyPullLow) begin
      if (wrote) begin
         nv_store();
      end
   end
   always @(negedge pins.ceN) begin
      a = pins.addr[13:0];
      rd = pins.weN;
      flt = rd && step == 5 && (a == 14'h0fc0 || a == 14'h0c63);
      #100;
      // no writes while busy or in holdoff
      if (!rd && !busy && $realtime >= freeAt) begin
         mem[pins.addr] = hostData;
         wrote = 1'b1;
      end
      if (!rd || step < 5) begin
         step = (rd && a == seqAddr[step]) ? step + 1 : int'(rd && a == seqAddr[0]);
      end else begin
         step = int'(a == seqAddr[0]);
         case (a)
            14'h0fc0: nv_store();
            14'h0c63: begin
               #200;
               mem = nvMem;
               recalls++;
               wrote = 1'b0;
            end
            14'h0b45: autoStore = 1'b0;
            14'h0b46: autoStore = 1'b1;
            default: ;
         endcase
         flt = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- nvsram_host_pkg.sv
// Shared constants and carrier types for the nonvolatile SRAM host controller.
// Assumes a 25 MHz system clock; all pin timing is derived from it.
`default_nettype none
package nvsram_host_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CMD_ADDR_W = 14;
   // Pin-level access time and holdoff after busy release
   localparam int T_ACCESS_NS = 45;
   localparam int T_HOLDOFF_NS = 20000;
   localparam int ACCESS_CYCLES = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLDOFF_CYCLES = (T_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Extra strobe cycles so read data passes the two-stage synchroniser
   localparam int SYNC_STAGES = 2;
   localparam int COUNT_W = 24;
   localparam int LAST_STEP = 5;
   // Command sequence addresses, low 14 bits only
   localparam logic [13:0] SEQ_ADDR_1 = 14'h0e38;
   localparam logic [13:0] SEQ_ADDR_2 = 14'h31c7;
   localparam logic [13:0] SEQ_ADDR_3 = 14'h03e0;
   localparam logic [13:0] SEQ_ADDR_4 = 14'h3c1f;
   localparam logic [13:0] SEQ_ADDR_5 = 14'h303f;
   localparam logic [13:0] SEQ_ADDR_RECALL = 14'h0c63;
   localparam logic [13:0] SEQ_ADDR_AS_OFF = 14'h0b45;
   localparam logic [13:0] SEQ_ADDR_AS_ON = 14'h0b46;
   localparam logic [13:0] SEQ_ADDR_STORE = 14'h0fc0;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_STORE = 3'h2,
      CMD_RECALL = 3'h3,
      CMD_AS_OFF = 3'h4,
      CMD_AS_ON = 3'h5,
      CMD_HW_STORE = 3'h6
   } cmd_t;

   typedef struct packed {
      cmd_t cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_t;

   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic [ADDR_W-1:0] addr;
   } pins_t;
endpackage
`default_nettype wire

//--- nvsram_soft_sequence_control.sv
// Host-side controller that drives an asynchronous nonvolatile SRAM.
// Assumes the SRAM pins are outside the clock domain; inputs are synchronised here.
// Contract
// - Recall needs five prefix reads then a read at the recall address.
// - Host issues the six reads back to back in exact order.
// - Write enable stays high through all six sequence reads.
// - A store must follow an enable change to make it persist.
`timescale 1ns/10ps
`default_nettype none
module nvsram_soft_sequence_control #(
   parameter int STORE_CYCLES = 200000,
   parameter int RECALL_CYCLES = 5000,
   parameter int HOLDOFF_CYCLES = nvsram_host_pkg::HOLDOFF_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   // User request port
   input wire logic reqValid,
   input wire nvsram_host_pkg::req_t req,
   output logic reqReady,
   output logic rspValid,
   output logic [nvsram_host_pkg::DATA_W-1:0] rspData,
   output logic opDone,
   // SRAM pins
   output nvsram_host_pkg::pins_t pins,
   input wire logic [nvsram_host_pkg::DATA_W-1:0] dataIn,
   output logic [nvsram_host_pkg::DATA_W-1:0] dataOut,
   output logic dataOe,
   input wire logic storeBusyIn,
   output logic storeBusyOut,
   output logic storeBusyOe
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ACC = 3'b001,
      S_NVWAIT = 3'b010,
      S_BUSY = 3'b011,
      S_HOLD = 3'b100
   } state_t;

   localparam int CW = nvsram_host_pkg::COUNT_W;

   state_t state;
   nvsram_host_pkg::cmd_t cmd;
   logic [nvsram_host_pkg::ADDR_W-1:0] userAddr;
   logic [nvsram_host_pkg::DATA_W-1:0] userData;
   logic [2:0] step;
   logic [CW-1:0] count;
   logic [nvsram_host_pkg::DATA_W-1:0] dataMeta;
   logic [nvsram_host_pkg::DATA_W-1:0] dataSync;
   logic busyMeta;
   logic busySync;
   logic accBusy;
   logic accDone;
   logic [nvsram_host_pkg::DATA_W-1:0] accData;

   // Address of one step of a command sequence; top address bit driven low
   function automatic logic [nvsram_host_pkg::ADDR_W-1:0] seq_addr(
      input logic [2:0] s,
      input nvsram_host_pkg::cmd_t c
   );
      logic [13:0] a;
      a = nvsram_host_pkg::SEQ_ADDR_STORE;
      case (s)
         3'h0: a = nvsram_host_pkg::SEQ_ADDR_1;
         3'h1: a = nvsram_host_pkg::SEQ_ADDR_2;
         3'h2: a = nvsram_host_pkg::SEQ_ADDR_3;
         3'h3: a = nvsram_host_pkg::SEQ_ADDR_4;
         3'h4: a = nvsram_host_pkg::SEQ_ADDR_5;
         default: begin
            case (c)
               nvsram_host_pkg::CMD_RECALL: a = nvsram_host_pkg::SEQ_ADDR_RECALL;
               nvsram_host_pkg::CMD_AS_OFF: a = nvsram_host_pkg::SEQ_ADDR_AS_OFF;
               nvsram_host_pkg::CMD_AS_ON: a = nvsram_host_pkg::SEQ_ADDR_AS_ON;
               default: a = nvsram_host_pkg::SEQ_ADDR_STORE;
            endcase
         end
      endcase
      return {1'b0, a};
   endfunction

   wire isSingle = (cmd == nvsram_host_pkg::CMD_READ) || (cmd == nvsram_host_pkg::CMD_WRITE);
   wire isWrite = (cmd == nvsram_host_pkg::CMD_WRITE);
   wire [nvsram_host_pkg::ADDR_W-1:0] accAddr = isSingle ? userAddr : seq_addr(step, cmd);
   wire accIsWrite = isSingle && isWrite;
   wire accStart = (state == S_ACC) && !accBusy && !accDone;
   wire lastStep = (step == 3'(nvsram_host_pkg::LAST_STEP));
   wire countZero = (count == '0);
   wire isModeCmd = (cmd == nvsram_host_pkg::CMD_AS_OFF) || (cmd == nvsram_host_pkg::CMD_AS_ON);
   wire isRecall = (cmd == nvsram_host_pkg::CMD_RECALL);

   assign reqReady = (state == S_IDLE);
   // Open-drain: only ever pulled low
   assign storeBusyOut = 1'b0;

   nvsram_access_cycle u_access (
      .clk(clk),
      .arst_n(arst_n),
      .start(accStart),
      .isWrite(accIsWrite),
      .addr(accAddr),
      .wdata(userData),
      .dataInSync(dataSync),
      .pins(pins),
      .dataOut(dataOut),
      .dataOe(dataOe),
      .rdata(accData),
      .busy(accBusy),
      .done(accDone)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dataMeta <= '0;
         dataSync <= '0;
         busyMeta <= 1'b1;
         busySync <= 1'b1;
      end else begin
         dataMeta <= dataIn;
         dataSync <= dataMeta;
         busyMeta <= storeBusyIn;
         busySync <= busyMeta;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         cmd <= nvsram_host_pkg::CMD_READ;
         userAddr <= '0;
         userData <= '0;
         step <= 3'h0;
         count <= '0;
         rspValid <= 1'b0;
         rspData <= '0;
         opDone <= 1'b0;
         storeBusyOe <= 1'b0;
      end else begin
         rspValid <= 1'b0;
         opDone <= 1'b0;
         case (state)
            S_IDLE: begin
               if (reqValid) begin
                  cmd <= req.cmd;
                  userAddr <= req.addr;
                  userData <= req.wdata;
                  step <= 3'h0;
                  if (req.cmd == nvsram_host_pkg::CMD_HW_STORE) begin
                     // Hold the request low until the store window ends
                     storeBusyOe <= 1'b1;
                     count <= CW'(STORE_CYCLES);
                     state <= S_NVWAIT;
                  end else begin
                     state <= S_ACC;
                  end
               end
            end
            S_ACC: begin
               if (accDone) begin
                  if (isSingle) begin
                     rspValid <= !isWrite;
                     rspData <= accData;
                     opDone <= 1'b1;
                     state <= S_IDLE;
                  end else if (!lastStep) begin
                     step <= step + 3'h1;
                  end else if (isModeCmd) begin
                     cmd <= nvsram_host_pkg::CMD_STORE;
                     step <= 3'h0;
                  end else begin
                     count <= isRecall ? CW'(RECALL_CYCLES) : CW'(STORE_CYCLES);
                     state <= S_NVWAIT;
                  end
               end
            end
            S_NVWAIT: begin
               if (countZero) begin
                  storeBusyOe <= 1'b0;
                  state <= S_BUSY;
               end else begin
                  count <= count - CW'(1);
               end
            end
            S_BUSY: begin
               // Device may stretch the store; wait for busy release
               if (busySync) begin
                  count <= CW'(HOLDOFF_CYCLES);
                  state <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (countZero) begin
                  opDone <= 1'b1;
                  state <= S_IDLE;
               end else begin
                  count <= count - CW'(1);
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- nvsram_soft_sequence_control_chk.sv
// Pin-level checks of the nonvolatile SRAM host controller.
// Assumes one clock domain; bound to the controller below.
`timescale 1ns/10ps
`default_nettype none
module nvsram_soft_sequence_control_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reqValid,
   input wire nvsram_host_pkg::req_t req,
   input wire logic reqReady,
   input wire nvsram_host_pkg::pins_t pins
);
   wire logic taken = reqValid && reqReady;
   wire logic seqReq = taken && req.cmd >= nvsram_host_pkg::CMD_STORE
      && req.cmd <= nvsram_host_pkg::CMD_AS_ON;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   read_we_a: assert property (!pins.ceN && !pins.oeN |-> pins.weN)
      else $error("write enable low in a read");
   strobe_hold_a: assert property ($fell(pins.ceN) |=> $stable(pins) [*4])
      else $error("pins changed inside a strobe");
   strobe_len_a: assert property ($fell(pins.ceN) |-> !pins.ceN [*5] ##1 pins.ceN)
      else $error("strobe not five cycles");
   seq_start_a: assert property (seqReq |-> ##[1:3] $fell(pins.ceN) && pins.weN
      && pins.addr[13:0] == nvsram_host_pkg::SEQ_ADDR_1)
      else $error("sequence did not open at first address");
   one_req_a: assert property (taken |=> !reqReady)
      else $error("second request accepted while busy");
endmodule
bind nvsram_soft_sequence_control nvsram_soft_sequence_control_chk chk (.clk(clk),
   .arst_n(arst_n), .reqValid(reqValid), .req(req), .reqReady(reqReady), .pins(pins));
`default_nettype wire

//--- test_nvsram_soft_sequence_control.sv
// Self-checking bench: controller against a behavioural device model.
// Assumes package, design and model files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_nvsram_soft_sequence_control;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic reqValid = 1'b0;
   nvsram_host_pkg::req_t req = '0;
   logic reqReady, rspValid, opDone, dataOe, storeBusyOut, storeBusyOe, busyPin;
   logic autoStore, autoStoreNv, gotValid;
   logic [7:0] rspData, dataOut, devData, got;
   nvsram_host_pkg::pins_t pins;
   int stores, recalls;
   int bad_count = 0;
   int checks = 0;
   wire logic [7:0] bus = dataOe ? dataOut : devData;
   always #20 clk = ~clk;
   nvsram_soft_sequence_control #(.STORE_CYCLES(20), .RECALL_CYCLES(10), .HOLDOFF_CYCLES(5)) dut (
      .clk(clk), .arst_n(arst_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .opDone(opDone), .pins(pins), .dataIn(bus),
      .dataOut(dataOut), .dataOe(dataOe), .storeBusyIn(busyPin),
      .storeBusyOut(storeBusyOut), .storeBusyOe(storeBusyOe));
   nvsram_device_model model (.pins(pins), .hostData(bus),
      .busyPullLow(storeBusyOe && !storeBusyOut), .devData(devData), .busyPin(busyPin),
      .stores(stores), .recalls(recalls), .autoStore(autoStore), .autoStoreNv(autoStoreNv));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic run(input nvsram_host_pkg::cmd_t c, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      while (reqReady !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (reqReady !== 1'b1) begin
         bad_count++;
         $display("unexpected ready wait: expected 1, seen 0");
         close_out();
      end
      req <= '{cmd: c, addr: a, wdata: d};
      reqValid <= 1'b1;
      @(posedge clk);
      reqValid <= 1'b0;
      n = 0;
      while (opDone !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      got = rspData;
      gotValid = rspValid;
      if (opDone !== 1'b1) begin
         bad_count++;
         $display("unexpected done wait: expected 1, seen 0");
         close_out();
      end
   endtask
   task automatic factory_state();
      run(nvsram_host_pkg::CMD_READ, 15'h0010, 8'h00);
      check("factory byte", 8'h00, got);
      check("factory autostore", 8'h01, 8'(autoStore));
      run(nvsram_host_pkg::CMD_WRITE, 15'h4123, 8'h5a);
      check("write valid", 8'h00, 8'(gotValid));
      run(nvsram_host_pkg::CMD_READ, 15'h4123, 8'h00);
      check("upper byte", 8'h5a, got);
      check("upper valid", 8'h01, 8'(gotValid));
   endtask
   task automatic store_recall();
      run(nvsram_host_pkg::CMD_WRITE, 15'h0123, 8'ha5);
      run(nvsram_host_pkg::CMD_STORE, 15'h0000, 8'h00);
      check("stores", 8'h01, 8'(stores));
      run(nvsram_host_pkg::CMD_WRITE, 15'h0123, 8'h3c);
      run(nvsram_host_pkg::CMD_RECALL, 15'h0000, 8'h00);
      check("recalls", 8'h01, 8'(recalls));
      run(nvsram_host_pkg::CMD_READ, 15'h0123, 8'h00);
      check("recalled byte", 8'ha5, got);
   endtask
   task automatic autostore_modes();
      run(nvsram_host_pkg::CMD_AS_OFF, 15'h0000, 8'h00);
      check("autostore off", 8'h00, 8'(autoStore));
      check("kept enable off", 8'h00, 8'(autoStoreNv));
      check("store after off", 8'h02, 8'(stores));
      run(nvsram_host_pkg::CMD_AS_ON, 15'h0000, 8'h00);
      check("kept enable on", 8'h01, 8'(autoStoreNv));
   endtask
   task automatic pin_store();
      run(nvsram_host_pkg::CMD_HW_STORE, 15'h0000, 8'h00);
      check("skipped pin store", 8'h03, 8'(stores));
      run(nvsram_host_pkg::CMD_WRITE, 15'h0200, 8'h11);
      run(nvsram_host_pkg::CMD_HW_STORE, 15'h0000, 8'h00);
      check("pin store", 8'h04, 8'(stores));
      check("busy drive level", 8'h00, 8'(storeBusyOut));
      run(nvsram_host_pkg::CMD_WRITE, 15'h0200, 8'h22);
      run(nvsram_host_pkg::CMD_READ, 15'h0200, 8'h00);
      check("write after holdoff", 8'h22, got);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      factory_state();
      store_recall();
      autostore_modes();
      pin_store();
      close_out();
   end
endmodule
`default_nettype wire
